// file: rtl/tqf_delay.sv
// four stage output delay line with a mailbox tap at stage two
`timescale 1ns/1ps
module tqf_delay (
    input wire logic i_clk,
    input wire logic i_rstn,
    tqf_pipe_if.dly pipe
);
    logic [tqf_pkg::READ_LAT-1:0] vld;
    logic [tqf_pkg::READ_LAT-1:0] next_vld;
    tqf_pkg::tqf_word_t dat [tqf_pkg::READ_LAT];
    tqf_pkg::tqf_word_t next_dat [tqf_pkg::READ_LAT];

    // ----------------------------------------------------------------
    // shift with injection
    // ----------------------------------------------------------------
    always_comb begin
        next_vld = {vld[tqf_pkg::READ_LAT-2:0], pipe.tap0_valid};
        next_dat[0] = pipe.tap0_data;
        for (int i = 1; i < tqf_pkg::READ_LAT; i++) begin
            next_dat[i] = dat[i-1];
        end
        if (pipe.tap2_valid) begin
            next_vld[tqf_pkg::PASS_LAT] = 1'b1;
            next_dat[tqf_pkg::PASS_LAT] = pipe.tap2_data;
        end
    end

    always_ff @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            vld <= '0;
            for (int i = 0; i < tqf_pkg::READ_LAT; i++) begin
                dat[i] <= '0;
            end
        end else begin
            vld <= next_vld;
            dat <= next_dat;
        end
    end

    assign pipe.out_valid = vld[tqf_pkg::READ_LAT-1];
    assign pipe.out_data = dat[tqf_pkg::READ_LAT-1];
endmodule

// file: rtl/tqf_pipe_if.sv
// carrier between the queue logic and the output delay line
`timescale 1ns/1ps
interface tqf_pipe_if;
    logic tap0_valid;
    tqf_pkg::tqf_word_t tap0_data;
    logic tap2_valid;
    tqf_pkg::tqf_word_t tap2_data;
    logic out_valid;
    tqf_pkg::tqf_word_t out_data;
    modport src (
        output tap0_valid, tap0_data, tap2_valid, tap2_data,
        input out_valid, out_data
    );
    modport dly (
        input tap0_valid, tap0_data, tap2_valid, tap2_data,
        output out_valid, out_data
    );
endinterface

// file: rtl/tqf_pkg.sv
// constants and types of the two-queue fifo latency model
// Notes on behaviour
// - full indicator goes low 0 to 4 cycles after the filling write
// - empty indicator goes low in the cycle of the last read
// - passthrough word reaches read data 2 cycles after its write
// - first fifo word appears 4 cycles after read strobe
// - read strobe with config load gives first config value 4 cycles later
// - full indicator returns high 7 cycles after read freeing space
// - replayed data valid 20 to 23 cycles after fifth replay cycle
// - first word after empty readable within 8 to 29 cycles; here readable 6 cycles after the write
// - empty indicator returns high 6 to 27 cycles after write
// - count 1024 edges of each port clock, first finisher is master
// - fast bit at 0xa reports write clock faster, host may override
package tqf_pkg;
    // ----------------------------------------------------------------
    // sizes
    // ----------------------------------------------------------------
    localparam int DATA_W = 36;
    localparam int DEPTH = 8;
    localparam int PTR_W = 3;
    localparam int CNT_W = 4;
    localparam int REG_W = 32;
    localparam int ADDR_W = 4;
    // ----------------------------------------------------------------
    // latencies in cycles
    // ----------------------------------------------------------------
    localparam int READ_LAT = 4;
    localparam int PASS_LAT = 2;
    localparam int FULL_RELEASE_CYC = 7;
    localparam int EMPTY_RELEASE_CYC = 6;
    localparam int REPLAY_HOLD_CYC = 5;
    localparam int REPLAY_DATA_MIN = 20;
    localparam int REPLAY_STALL_CYC = REPLAY_DATA_MIN - READ_LAT - 1;
    localparam int MEAS_CYC = 1024;
    localparam int MEAS_W = 10;
    localparam int TMR_W = 5;
    // ----------------------------------------------------------------
    // register map
    // ----------------------------------------------------------------
    localparam logic [ADDR_W-1:0] REG_STATUS = 4'h0;
    localparam logic [ADDR_W-1:0] REG_FAST = 4'ha;
    localparam logic [ADDR_W-1:0] REG_MARK = 4'hb;
    localparam int STAT_CNT0 = 0;
    localparam int STAT_CNT1 = 4;
    localparam int STAT_DONE = 8;
    localparam int MARK_GO = 0;
    localparam int MARK_Q = 1;
    localparam int MARK_POS0 = 4;
    localparam int MARK_POS1 = 8;
    localparam logic FAST_RESET = 1'h0;
    typedef logic [DATA_W-1:0] tqf_word_t;
endpackage

// file: rtl/tqf_top.sv
// two-queue fifo with latency-exact flags, mailbox and replay
`timescale 1ns/1ps
module tqf_top (
    input wire logic i_clk,
    input wire logic i_rstn,
    input wire logic [35:0] i_wdata,
    input wire logic i_write_n,
    input wire logic i_write_queue_pick,
    input wire logic i_read_n,
    input wire logic i_read_queue_pick,
    input wire logic i_config_load_select_n,
    input wire logic i_passthrough_select,
    input wire logic i_replay_request,
    input wire logic i_wr_port_clk,
    input wire logic i_rd_port_clk,
    input wire logic [3:0] i_reg_addr,
    input wire logic [31:0] i_reg_wdata,
    input wire logic i_reg_we,
    input wire logic i_reg_re,
    output logic [31:0] o_reg_rdata,
    output logic [35:0] o_rdata,
    output logic o_rdata_valid,
    output logic o_full_indicator_n,
    output logic o_empty_indicator_n
);
    localparam int D = tqf_pkg::DEPTH;
    localparam int CW = tqf_pkg::CNT_W;
    localparam int PW = tqf_pkg::PTR_W;
    localparam int TW = tqf_pkg::TMR_W;
    localparam int MW = tqf_pkg::MEAS_W;

    tqf_pkg::tqf_word_t mem [2][D];
    logic [PW-1:0] wptr [2], next_wptr [2], rptr [2], next_rptr [2];
    logic [PW-1:0] mark [2], next_mark [2];
    logic [CW-1:0] cnt [2], next_cnt [2];
    logic [TW-1:0] eftmr [2], next_eftmr [2], fftmr [2], next_fftmr [2];
    logic [TW-1:0] rtmr, next_rtmr;
    logic [2:0] rtcnt, next_rtcnt;
    logic [3:0] cfg_ptr, next_cfg_ptr;
    logic [MW-1:0] wmeas, next_wmeas, rmeas, next_rmeas;
    logic wclk_q, rclk_q, meas_done, next_meas_done, fast, next_fast;
    logic [31:0] next_reg_rdata;
    logic [1:0] ready, full_n_q;
    logic push, pop, pass_take, cfg_take, replay_fifth, w_end, r_end;
    tqf_pkg::tqf_word_t pop_data, cfg_word;
    tqf_pipe_if pipe ();

    // ----------------------------------------------------------------
    // register view
    // ----------------------------------------------------------------
    function automatic logic [31:0] reg_value(input logic [3:0] a);
        logic [31:0] v;
        v = '0;
        if (a == tqf_pkg::REG_STATUS) begin
            v[tqf_pkg::STAT_CNT0 +: CW] = cnt[0];
            v[tqf_pkg::STAT_CNT1 +: CW] = cnt[1];
            v[tqf_pkg::STAT_DONE] = meas_done;
        end else if (a == tqf_pkg::REG_FAST) begin
            v[0] = fast;
        end else if (a == tqf_pkg::REG_MARK) begin
            v[tqf_pkg::MARK_POS0 +: PW] = mark[0];
            v[tqf_pkg::MARK_POS1 +: PW] = mark[1];
        end
        return v;
    endfunction

    // ----------------------------------------------------------------
    // flags and takes
    // ----------------------------------------------------------------
    always_comb begin
        for (int q = 0; q < 2; q++) begin
            ready[q] = (cnt[q] != '0) && (eftmr[q] == '0);
            // low once the queue holds the last word
            full_n_q[q] = (cnt[q] != CW'(D)) && (fftmr[q] == '0);
        end
    end

    assign push = !i_write_n && !i_passthrough_select &&
                  full_n_q[i_write_queue_pick];
    assign pass_take = !i_write_n && i_passthrough_select;
    assign cfg_take = !i_read_n && !i_config_load_select_n;
    assign pop = !i_read_n && i_config_load_select_n &&
                 !i_passthrough_select && !i_replay_request &&
                 ready[i_read_queue_pick] && (rtmr == '0);
    assign replay_fifth = i_replay_request &&
                      (rtcnt == 3'(tqf_pkg::REPLAY_HOLD_CYC - 1));
    assign pop_data = mem[i_read_queue_pick][rptr[i_read_queue_pick]];
    always_comb cfg_word = tqf_pkg::tqf_word_t'(reg_value(cfg_ptr));
    assign w_end = i_wr_port_clk && !wclk_q &&
                   (wmeas == MW'(tqf_pkg::MEAS_CYC - 1));
    assign r_end = i_rd_port_clk && !rclk_q &&
                   (rmeas == MW'(tqf_pkg::MEAS_CYC - 1));

    assign o_full_indicator_n = full_n_q[i_write_queue_pick];
    // falls with the read of the last word
    assign o_empty_indicator_n = ready[i_read_queue_pick] &&
        !(pop && cnt[i_read_queue_pick] == CW'(1));

    assign pipe.tap0_valid = pop || cfg_take;
    assign pipe.tap0_data = cfg_take ? cfg_word : pop_data;
    assign pipe.tap2_valid = pass_take;
    assign pipe.tap2_data = i_wdata;
    assign o_rdata = pipe.out_data;
    assign o_rdata_valid = pipe.out_valid;

    tqf_delay u_delay (
        .i_clk(i_clk),
        .i_rstn(i_rstn),
        .pipe(pipe)
    );

    // ----------------------------------------------------------------
    // queue state
    // ----------------------------------------------------------------
    always_comb begin
        next_wptr = wptr;
        next_rptr = rptr;
        next_mark = mark;
        next_cnt = cnt;
        next_rtmr = (rtmr != '0) ? rtmr - TW'(1) : rtmr;
        next_rtcnt = '0;
        next_cfg_ptr = cfg_ptr;
        for (int q = 0; q < 2; q++) begin
            next_eftmr[q] = (eftmr[q] != '0) ? eftmr[q] - TW'(1) : eftmr[q];
            next_fftmr[q] = (fftmr[q] != '0) ? fftmr[q] - TW'(1) : fftmr[q];
            next_cnt[q] = cnt[q]
                + CW'(push && (i_write_queue_pick == 1'(q)))
                - CW'(pop && (i_read_queue_pick == 1'(q)));
        end
        if (push) begin
            next_wptr[i_write_queue_pick] = wptr[i_write_queue_pick] + PW'(1);
            if (cnt[i_write_queue_pick] == '0) begin
                next_eftmr[i_write_queue_pick] =
                    TW'(tqf_pkg::EMPTY_RELEASE_CYC - 1);
            end
        end
        if (pop) begin
            next_rptr[i_read_queue_pick] = rptr[i_read_queue_pick] + PW'(1);
            // keep full low for the release delay
            if (cnt[i_read_queue_pick] == CW'(D)) begin
                next_fftmr[i_read_queue_pick] =
                    TW'(tqf_pkg::FULL_RELEASE_CYC - 1);
            end
        end
        if (cfg_take) begin
            next_cfg_ptr = (cfg_ptr == tqf_pkg::REG_MARK) ? 4'h0 :
                           cfg_ptr + 4'h1;
        end
        if (i_replay_request) begin
            next_rtcnt = (rtcnt == 3'(tqf_pkg::REPLAY_HOLD_CYC)) ? rtcnt :
                         rtcnt + 3'h1;
        end
        // reload from mark and stall reads
        if (replay_fifth) begin
            next_rptr[i_read_queue_pick] = mark[i_read_queue_pick];
            next_cnt[i_read_queue_pick] = next_cnt[i_read_queue_pick] +
                CW'(PW'(rptr[i_read_queue_pick] - mark[i_read_queue_pick]));
            next_rtmr = TW'(tqf_pkg::REPLAY_STALL_CYC);
        end
        if (i_reg_we && i_reg_addr == tqf_pkg::REG_MARK &&
            i_reg_wdata[tqf_pkg::MARK_GO]) begin
            next_mark[i_reg_wdata[tqf_pkg::MARK_Q]] =
                rptr[i_reg_wdata[tqf_pkg::MARK_Q]];
        end
    end

    always_ff @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            for (int q = 0; q < 2; q++) begin
                wptr[q] <= '0;
                rptr[q] <= '0;
                mark[q] <= '0;
                cnt[q] <= '0;
                eftmr[q] <= '0;
                fftmr[q] <= '0;
            end
            rtmr <= '0;
            rtcnt <= '0;
            cfg_ptr <= '0;
        end else begin
            wptr <= next_wptr;
            rptr <= next_rptr;
            mark <= next_mark;
            cnt <= next_cnt;
            eftmr <= next_eftmr;
            fftmr <= next_fftmr;
            rtmr <= next_rtmr;
            rtcnt <= next_rtcnt;
            cfg_ptr <= next_cfg_ptr;
        end
    end

    always_ff @(posedge i_clk) begin
        if (push) begin
            mem[i_write_queue_pick][wptr[i_write_queue_pick]] <= i_wdata;
        end
    end

    // ----------------------------------------------------------------
    // clock measurement and registers
    // ----------------------------------------------------------------
    always_comb begin
        next_wmeas = wmeas;
        next_rmeas = rmeas;
        next_meas_done = meas_done;
        next_fast = fast;
        next_reg_rdata = i_reg_re ? reg_value(i_reg_addr) : '0;
        if (i_reg_we && i_reg_addr == tqf_pkg::REG_FAST) begin
            next_fast = i_reg_wdata[0];
        end
        // first counter to finish names the master
        if (!meas_done) begin
            if (i_wr_port_clk && !wclk_q) next_wmeas = wmeas + MW'(1);
            if (i_rd_port_clk && !rclk_q) next_rmeas = rmeas + MW'(1);
            // measured result beats a same-cycle write
            if (w_end || r_end) begin
                next_meas_done = 1'b1;
                next_fast = w_end;
            end
        end
    end

    always_ff @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            wmeas <= '0;
            rmeas <= '0;
            wclk_q <= 1'b0;
            rclk_q <= 1'b0;
            meas_done <= 1'b0;
            fast <= tqf_pkg::FAST_RESET;
            o_reg_rdata <= '0;
        end else begin
            wmeas <= next_wmeas;
            rmeas <= next_rmeas;
            wclk_q <= i_wr_port_clk;
            rclk_q <= i_rd_port_clk;
            meas_done <= next_meas_done;
            fast <= next_fast;
            o_reg_rdata <= next_reg_rdata;
        end
    end

    // ----------------------------------------------------------------
    // checks
    // ----------------------------------------------------------------
    default clocking cb @(posedge i_clk);
    endclocking
    default disable iff (!i_rstn);

    full_assert_a: assert property (
        (push && !i_write_queue_pick && cnt[0] == CW'(D - 1) &&
         !(pop && !i_read_queue_pick)) |=> !full_n_q[0])
        else $error("full not asserted after filling write");
    empty_same_a: assert property (
        (pop && cnt[i_read_queue_pick] == CW'(1)) |-> !o_empty_indicator_n)
        else $error("empty not low with last read");
    mailbox_lat_a: assert property (
        pass_take |-> ##2 (o_rdata_valid && o_rdata == $past(i_wdata, 2)))
        else $error("mailbox word not out after two cycles");
    read_lat_a: assert property (
        (pop && !pass_take) |-> ##4 (o_rdata_valid &&
            o_rdata == $past(pop_data, 4)))
        else $error("fifo word not out after four cycles");
    config_lat_a: assert property (
        cfg_take |-> ##4 (o_rdata == $past(cfg_word, 4)))
        else $error("config word not out after four cycles");
    full_release_a: assert property (
        (pop && !i_read_queue_pick && cnt[0] == CW'(D)) |=>
            !full_n_q[0] [*6] ##1 full_n_q[0])
        else $error("full release not at seven cycles");
    replay_stall_a: assert property (
        replay_fifth |=> (!pop) ##14 (rtmr == TW'(1)) ##1 (rtmr == '0))
        else $error("replay stall length wrong");
    empty_release_a: assert property (
        (push && !i_write_queue_pick && cnt[0] == '0) |=>
            !ready[0] [*5] ##1 ready[0])
        else $error("empty release not at six cycles");
    clock_pick_a: assert property (
        (!meas_done && w_end) |=> (meas_done && fast))
        else $error("write clock not chosen as faster");

    mailbox_c: cover property (pass_take ##2 o_rdata_valid);
    replay_c: cover property (replay_fifth ##16 pop);
    full_c: cover property (!o_full_indicator_n ##1 pop);
    // first word after empty becomes readable
    refill_c: cover property (!ready[0] ##1 push ##6 pop);
endmodule

// file: testbench/test_two_queue_fifo_latency_model.sv
// self-checking bench of the two-queue fifo latency model
`timescale 1ns/1ps
module test_two_queue_fifo_latency_model;
    typedef struct {
        int due;
        tqf_pkg::tqf_word_t data;
        bit care;
    } tqf_exp_t;
    logic i_clk, i_rstn, i_write_n, i_write_queue_pick, i_read_n;
    logic i_read_queue_pick, i_config_load_select_n, i_passthrough_select;
    logic i_reg_we, i_reg_re, replay_go, wr_pclk, rd_pclk, replay;
    logic [35:0] i_wdata, o_rdata;
    logic [3:0] i_reg_addr;
    logic [31:0] i_reg_wdata, o_reg_rdata, seed;
    logic o_rdata_valid, o_full_indicator_n, o_empty_indicator_n;
    int cyc = 0;
    int error_cnt = 0;
    int n_tests = 0;
    int k, b, i;
    tqf_exp_t exp_q[$];
    tqf_exp_t e_now;
    tqf_pkg::tqf_word_t w[9];

    tqf_top dut (.i_clk(i_clk), .i_rstn(i_rstn), .i_wdata(i_wdata),
        .i_write_n(i_write_n), .i_write_queue_pick(i_write_queue_pick),
        .i_read_n(i_read_n), .i_read_queue_pick(i_read_queue_pick),
        .i_config_load_select_n(i_config_load_select_n),
        .i_passthrough_select(i_passthrough_select),
        .i_replay_request(replay), .i_wr_port_clk(wr_pclk),
        .i_rd_port_clk(rd_pclk), .i_reg_addr(i_reg_addr),
        .i_reg_wdata(i_reg_wdata), .i_reg_we(i_reg_we),
        .i_reg_re(i_reg_re), .o_reg_rdata(o_reg_rdata),
        .o_rdata(o_rdata), .o_rdata_valid(o_rdata_valid),
        .o_full_indicator_n(o_full_indicator_n),
        .o_empty_indicator_n(o_empty_indicator_n));
    tqf_host_model host (.i_clk(i_clk), .i_rstn(i_rstn),
        .i_replay_go(replay_go), .o_wr_port_clk(wr_pclk),
        .o_rd_port_clk(rd_pclk), .o_replay_request(replay));

    // ----------------------------------------------------------------
    // helpers
    // ----------------------------------------------------------------
    task automatic chk(input logic [35:0] got, input logic [35:0] exp);
        n_tests++;
        if (got !== exp) begin
            error_cnt++;
            $display("unexpected at %0t: got %h want %h", $time, got, exp);
        end
    endtask
    task automatic flg(input logic got, input logic exp);
        chk(36'(got), 36'(exp));
    endtask
    function automatic tqf_pkg::tqf_word_t rnd();
        seed = {seed[30:0], seed[31] ^ seed[21] ^ seed[1] ^ seed[0]};
        return {seed[3:0], seed};
    endfunction
    task automatic op(input logic wr, rd, ld, mb,
                      input tqf_pkg::tqf_word_t d);
        @(posedge i_clk);
        k = cyc + 1;
        i_write_n <= !wr;
        i_read_n <= !rd;
        i_config_load_select_n <= !ld;
        i_passthrough_select <= mb;
        i_wdata <= d;
    endtask
    task automatic idle();
        op(1'b0, 1'b0, 1'b0, 1'b0, 36'h0);
    endtask
    task automatic push(input int due, input tqf_pkg::tqf_word_t d,
                        input bit c);
        exp_q.push_back('{due, d, c});
    endtask
    task automatic at_neg(input int n);
        wait (cyc == n);
        @(negedge i_clk);
    endtask
    task automatic reg_op(input logic we, input logic [3:0] a,
                          input logic [31:0] d);
        @(posedge i_clk);
        i_reg_we <= we;
        i_reg_re <= !we;
        i_reg_addr <= a;
        i_reg_wdata <= d;
        @(posedge i_clk);
        i_reg_we <= 1'b0;
        i_reg_re <= 1'b0;
    endtask
    task automatic reg_rd(input logic [3:0] a, input logic [31:0] x);
        reg_op(1'b0, a, 32'h0);
        @(negedge i_clk);
        chk(36'(o_reg_rdata), 36'(x));
    endtask
    task automatic give_verdict();
        if (error_cnt == 0 && n_tests > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    initial begin
        i_clk = 1'b0;
        forever #12.5 i_clk = ~i_clk;
    end
    always @(posedge i_clk) cyc <= cyc + 1;
    initial begin
        #(25 * 8000);
        error_cnt++;
        give_verdict();
    end
    // output watcher: every read result against the oldest note
    always @(negedge i_clk) begin
        if (i_rstn && o_rdata_valid !== 1'b0) begin
            if (exp_q.size() == 0) begin
                flg(o_rdata_valid, 1'b0);
            end else begin
                e_now = exp_q.pop_front();
                chk(36'(cyc), 36'(e_now.due));
                if (e_now.care) chk(o_rdata, e_now.data);
            end
        end
    end

    // ----------------------------------------------------------------
    // scenarios
    // ----------------------------------------------------------------
    initial begin
        {i_rstn, i_write_queue_pick, i_read_queue_pick} = 3'h0;
        {i_write_n, i_read_n, i_config_load_select_n} = 3'h7;
        {i_passthrough_select, i_reg_we, i_reg_re, replay_go} = 4'h0;
        i_wdata = 36'h0;
        i_reg_addr = 4'h0;
        i_reg_wdata = 32'h0;
        seed = 32'h3aa9f9d2;
        repeat (4) @(posedge i_clk);
        i_rstn <= 1'b1;
        @(negedge i_clk);
        flg(o_full_indicator_n, 1'b1);
        flg(o_empty_indicator_n, 1'b0);
        reg_rd(tqf_pkg::REG_FAST, 32'(tqf_pkg::FAST_RESET));
        // no further access before the clock check has settled
        wait (cyc == 2100);
        reg_rd(tqf_pkg::REG_FAST, 32'h1);
        reg_rd(tqf_pkg::REG_STATUS, 32'h100);
        reg_op(1'b1, tqf_pkg::REG_FAST, 32'h0);
        reg_rd(tqf_pkg::REG_FAST, 32'h0);
        reg_op(1'b1, tqf_pkg::REG_FAST, 32'h1);
        reg_rd(tqf_pkg::REG_FAST, 32'h1);
        reg_op(1'b1, 4'h5, 32'hffffffff);
        reg_rd(4'h5, 32'h0);
        // settle after the fast bit change
        repeat (1100) idle();
        @(posedge i_clk);
        b = cyc + 1;
        fork
            for (i = 0; i < 9; i++) begin
                w[i] = rnd();
                op(1'b1, 1'b0, 1'b0, 1'b0, w[i]);
            end
            begin
                at_neg(b + 6);
                flg(o_empty_indicator_n, 1'b0);
                at_neg(b + 7);
                flg(o_empty_indicator_n, 1'b1);
                at_neg(b + 8);
                flg(o_full_indicator_n, 1'b1);
                at_neg(b + 9);
                flg(o_full_indicator_n, 1'b0);
            end
        join
        idle();
        @(posedge i_clk);
        b = cyc + 1;
        fork
            for (i = 0; i < 8; i++) begin
                op(1'b0, 1'b1, 1'b0, 1'b0, 36'h0);
                push(k + 4, w[i], 1'b1);
            end
            begin
                at_neg(b + 7);
                flg(o_full_indicator_n, 1'b0);
                flg(o_empty_indicator_n, 1'b1);
                at_neg(b + 8);
                flg(o_full_indicator_n, 1'b1);
                flg(o_empty_indicator_n, 1'b0);
            end
        join
        repeat (2) idle();
        w[0] = rnd();
        op(1'b1, 1'b0, 1'b0, 1'b1, w[0]);
        push(k + 2, w[0], 1'b1);
        idle();
        op(1'b0, 1'b1, 1'b1, 1'b0, 36'h0);
        push(k + 4, 36'h100, 1'b1);
        idle();
        w[0] = rnd();
        op(1'b1, 1'b1, 1'b0, 1'b0, w[0]);
        push(k + 10, w[0], 1'b1);
        repeat (9) op(1'b0, 1'b1, 1'b0, 1'b0, 36'h0);
        idle();
        // picks held two cycles around each access
        @(posedge i_clk);
        i_write_queue_pick <= 1'b1;
        i_read_queue_pick <= 1'b1;
        repeat (2) idle();
        w[0] = rnd();
        op(1'b1, 1'b0, 1'b0, 1'b0, w[0]);
        repeat (8) idle();
        op(1'b0, 1'b1, 1'b0, 1'b0, 36'h0);
        push(k + 4, w[0], 1'b1);
        repeat (2) idle();
        i_write_queue_pick <= 1'b0;
        i_read_queue_pick <= 1'b0;
        repeat (2) idle();
        reg_op(1'b1, tqf_pkg::REG_MARK, 32'h1);
        for (i = 0; i < 2; i++) begin
            w[i] = rnd();
            op(1'b1, 1'b0, 1'b0, 1'b0, w[i]);
        end
        repeat (10) idle();
        for (i = 0; i < 2; i++) begin
            op(1'b0, 1'b1, 1'b0, 1'b0, 36'h0);
            push(k + 4, w[i], 1'b1);
        end
        repeat (6) idle();
        @(posedge i_clk);
        b = cyc + 1;
        replay_go <= 1'b1;
        @(posedge i_clk);
        replay_go <= 1'b0;
        repeat (12) idle();
        // read held low from nine cycles after the fifth
        for (i = 0; i < 9; i++) begin
            op(1'b0, 1'b1, 1'b0, 1'b0, 36'h0);
        end
        k = b + tqf_pkg::REPLAY_HOLD_CYC + tqf_pkg::REPLAY_DATA_MIN;
        for (i = 0; i < 2; i++) begin
            push(k + i, w[i], 1'b1);
        end
        repeat (10) idle();
        chk(36'(exp_q.size()), 36'h0);
        give_verdict();
    end
endmodule

// file: testbench/tqf_host_model.sv
// host side model: port clock levels and replay request hold
`timescale 1ns/1ps
module tqf_host_model #(
    parameter int WR_DIV = 1,
    parameter int RD_DIV = 2
) (
    input wire logic i_clk,
    input wire logic i_rstn,
    input wire logic i_replay_go,
    output logic o_wr_port_clk,
    output logic o_rd_port_clk,
    output logic o_replay_request
);
    int wr_cnt;
    int rd_cnt;
    int rt_cnt;
    // ----------------------------------------------------------------
    // port clocks and replay
    // ----------------------------------------------------------------
    // request held five cycles
    assign o_replay_request = (rt_cnt != 0);
    always @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            wr_cnt <= 0;
            rd_cnt <= 0;
            rt_cnt <= 0;
            o_wr_port_clk <= 1'b0;
            o_rd_port_clk <= 1'b0;
        end else begin
            // port clocks keep a steady rate
            wr_cnt <= (wr_cnt == WR_DIV - 1) ? 0 : wr_cnt + 1;
            rd_cnt <= (rd_cnt == RD_DIV - 1) ? 0 : rd_cnt + 1;
            if (wr_cnt == WR_DIV - 1) begin
                o_wr_port_clk <= !o_wr_port_clk;
            end
            if (rd_cnt == RD_DIV - 1) begin
                o_rd_port_clk <= !o_rd_port_clk;
            end
            if (i_replay_go) begin
                rt_cnt <= 5;
            end else if (rt_cnt != 0) begin
                rt_cnt <= rt_cnt - 1;
            end
        end
    end
endmodule
